/* logic/psabs_top.sv */
/*
 Pipelined burst SRAM core: strobe decode, burst addressing, byte-lane
 writes, registered reads, output enable and sleep sequencing.
 Assumes all inputs but output_drive_en_n and sleep_request are
 synchronous to sys_clk; the bench resolves the shared data wire.
*/
// What this block does
// - Controller strobe write needs all selects, write lanes
// - Controller write completes in one cycle, loads address
// - Ignore burst step on controller write launch
// - Global write all lanes, byte write selected only
// - Float data bus whenever write detected
// - Two-bit counter replaces low address bits
// - Strap high interleaved, low linear
// - Interleaved order is start XOR count
// - Linear order is start plus count mod four
// - Burst step low advances counter
// - No strobe, step high: reuse current address
// - Select one high, controller strobe high: continue
// - Deselect cases float the data bus
// - Processor strobe launch always reads
// - Controller launch writes if write indication active
// - Write indication: global, or byte enable plus lane
// - Output enable asynchronous, masked during writes
// - Sleep request floats bus, ignores inputs
// - Two cycles into and out of sleep
// - Read data appears after the next edge
// - Launch cycle out of deselect keeps bus floating
// - Processor access ignores write controls first cycle
module psabs_top #(
    parameter int ADDR_W = psabs_pkg::ADDR_W,
    parameter int LANES  = psabs_pkg::LANES,
    parameter int LANE_W = psabs_pkg::LANE_W
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // Strobes and selects
    input  wire logic                    controller_addr_strobe_n,
    input  wire logic                    processor_addr_strobe_n,
    input  wire logic                    burst_step_n,
    input  wire logic                    chip_sel_1_n,
    input  wire logic                    chip_sel_2,
    input  wire logic                    chip_sel_3_n,
    // Write controls
    input  wire logic                    global_write_n,
    input  wire logic                    byte_write_en_n,
    input  wire logic [LANES-1:0]        byte_lane_write_n,
    // Address and configuration
    input  wire logic [ADDR_W-1:0]       addr,
    input  wire logic                    burst_order_strap,
    // Asynchronous controls
    input  wire logic                    output_drive_en_n,
    input  wire logic                    sleep_request,
    // Shared data bus
    input  wire logic [LANES*LANE_W-1:0] data_io_bus_i,
    output logic      [LANES*LANE_W-1:0] data_io_bus_o,
    output logic                         data_io_bus_oe
);
    localparam int BW = psabs_pkg::BURST_W;

    psabs_pkg::psabs_sleep_t sleep_st_r;
    psabs_pkg::psabs_sleep_t sleep_st_nxt;
    logic [1:0]              sleep_cnt_r;
    logic [1:0]              sleep_cnt_nxt;
    logic                    order_r;
    logic                    order_nxt;
    logic                    selected_r;
    logic                    selected_nxt;
    logic                    rd_valid_r;
    logic                    rd_valid_nxt;
    logic [ADDR_W-1:0]       hi_addr_r;
    logic [ADDR_W-1:0]       hi_addr_nxt;

    logic                    awake;
    logic                    sel_all;
    logic                    wr_ind;
    logic                    begin_p;
    logic                    begin_c;
    logic                    deselect;
    logic                    cont;
    logic                    wr_cycle;
    logic                    rd_cycle;
    logic [LANES-1:0]        lane_we;
    logic [ADDR_W-1:0]       mem_addr;
    logic [BW-1:0]           cur_lo;
    logic [BW-1:0]           next_lo;
    logic [LANES*LANE_W-1:0] rdata;

    // Access decode
    always_comb begin
        awake    = (sleep_st_r == psabs_pkg::PSABS_AWAKE) && !sleep_request;
        sel_all  = !chip_sel_1_n && chip_sel_2 && !chip_sel_3_n;
        wr_ind   = !global_write_n || (!byte_write_en_n && !(&byte_lane_write_n));
        begin_p  = awake && sel_all && !processor_addr_strobe_n;
        begin_c  = awake && sel_all && processor_addr_strobe_n
                   && !controller_addr_strobe_n;
        deselect = awake && ((chip_sel_1_n && !controller_addr_strobe_n)
                   || (!chip_sel_1_n && !sel_all
                       && (!processor_addr_strobe_n || !controller_addr_strobe_n)));
        cont     = awake && selected_r && controller_addr_strobe_n
                   && (processor_addr_strobe_n || chip_sel_1_n);
        wr_cycle = (begin_c && wr_ind) || (cont && wr_ind);
        rd_cycle = begin_p || (begin_c && !wr_ind) || (cont && !wr_ind);
    end

    // Address selection and lane enables
    always_comb begin
        if (begin_p || begin_c) begin
            mem_addr = addr;
        end else if (!burst_step_n) begin
            mem_addr = {hi_addr_r[ADDR_W-1:BW], next_lo};
        end else begin
            mem_addr = {hi_addr_r[ADDR_W-1:BW], cur_lo};
        end
        if (!wr_cycle) begin
            lane_we = '0;
        end else if (!global_write_n) begin
            lane_we = '1;
        end else begin
            lane_we = ~byte_lane_write_n;
        end
    end

    // Access state
    always_comb begin
        order_nxt    = srst ? burst_order_strap : order_r;
        hi_addr_nxt  = (begin_p || begin_c) ? addr : hi_addr_r;
        selected_nxt = selected_r;
        if (begin_p || begin_c) begin
            selected_nxt = 1'b1;
        end else if (deselect || sleep_st_r != psabs_pkg::PSABS_AWAKE) begin
            selected_nxt = 1'b0;
        end
        rd_valid_nxt = rd_cycle;
    end

    always_ff @(posedge sys_clk) begin
        order_r <= order_nxt;
        if (srst) begin
            selected_r <= 1'b0;
            rd_valid_r <= 1'b0;
            hi_addr_r  <= '0;
        end else begin
            selected_r <= selected_nxt;
            rd_valid_r <= rd_valid_nxt;
            hi_addr_r  <= hi_addr_nxt;
        end
    end

    // Sleep sequencing
    always_comb begin
        sleep_st_nxt  = sleep_st_r;
        sleep_cnt_nxt = sleep_cnt_r;
        unique case (sleep_st_r)
            psabs_pkg::PSABS_AWAKE: begin
                if (sleep_request) begin
                    sleep_st_nxt  = psabs_pkg::PSABS_ENTER;
                    sleep_cnt_nxt = psabs_pkg::SLEEP_ENTRY_LOAD;
                end
            end
            psabs_pkg::PSABS_ENTER: begin
                if (!sleep_request) begin
                    sleep_st_nxt  = psabs_pkg::PSABS_LEAVE;
                    sleep_cnt_nxt = psabs_pkg::SLEEP_RECOV_LOAD;
                end else if (sleep_cnt_r == 2'h0) begin
                    sleep_st_nxt = psabs_pkg::PSABS_ASLEEP;
                end else begin
                    sleep_cnt_nxt = sleep_cnt_r - 2'h1;
                end
            end
            psabs_pkg::PSABS_ASLEEP: begin
                if (!sleep_request) begin
                    sleep_st_nxt  = psabs_pkg::PSABS_LEAVE;
                    sleep_cnt_nxt = psabs_pkg::SLEEP_RECOV_LOAD;
                end
            end
            psabs_pkg::PSABS_LEAVE: begin
                if (sleep_request) begin
                    sleep_st_nxt  = psabs_pkg::PSABS_ENTER;
                    sleep_cnt_nxt = psabs_pkg::SLEEP_ENTRY_LOAD;
                end else if (sleep_cnt_r == 2'h0) begin
                    sleep_st_nxt = psabs_pkg::PSABS_AWAKE;
                end else begin
                    sleep_cnt_nxt = sleep_cnt_r - 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sleep_st_r  <= psabs_pkg::PSABS_AWAKE;
            sleep_cnt_r <= 2'h0;
        end else begin
            sleep_st_r  <= sleep_st_nxt;
            sleep_cnt_r <= sleep_cnt_nxt;
        end
    end

    psabs_burst u_burst (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .load       (begin_p || begin_c),
        .start_lo   (addr[BW-1:0]),
        .step       (cont && !burst_step_n),
        .interleave (order_r),
        .cur_lo     (cur_lo),
        .next_lo    (next_lo)
    );

    psabs_mem #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) u_mem (
        .sys_clk (sys_clk),
        .addr    (mem_addr),
        .lane_we (lane_we),
        .rd_en   (rd_cycle),
        .wdata   (data_io_bus_i),
        .rdata   (rdata)
    );

    // Drive only on a live read with the enable low
    assign data_io_bus_o  = rdata;
    assign data_io_bus_oe = rd_valid_r && selected_r && !output_drive_en_n
                            && !wr_cycle && !sleep_request
                            && sleep_st_r == psabs_pkg::PSABS_AWAKE;

    wr_float_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_cycle |-> !data_io_bus_oe) else $error("bus driven during write");
    sleep_float_a: assert property (@(posedge sys_clk) disable iff (srst)
        sleep_request |-> !data_io_bus_oe) else $error("bus driven in sleep");
    rd_latency_a: assert property (@(posedge sys_clk) disable iff (srst)
        rd_cycle && !deselect |=> rd_valid_r && rdata == $past(u_mem.mem[mem_addr]))
        else $error("read data not one cycle later");
    first_float_a: assert property (@(posedge sys_clk) disable iff (srst)
        !selected_r |-> !data_io_bus_oe) else $error("bus driven while deselected");
    padsp_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_p |-> lane_we == '0 && rd_cycle) else $error("processor launch wrote");
    cwrite_load_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_c && wr_ind |-> mem_addr == addr && lane_we != '0 ##1 cur_lo == $past(addr[1:0]))
        else $error("controller write not loaded");
    byte_lane_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_cycle && global_write_n |-> lane_we == ~byte_lane_write_n)
        else $error("wrong write lanes");
    suspend_a: assert property (@(posedge sys_clk) disable iff (srst)
        cont && burst_step_n |-> mem_addr[1:0] == cur_lo ##1 cur_lo == $past(cur_lo))
        else $error("suspend moved address");
    interleave_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_p && order_r ##1 cont && !burst_step_n |-> mem_addr[1:0] == ($past(addr[1:0]) ^ 2'h1))
        else $error("interleaved step wrong");
    linear_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_p && !order_r ##1 cont && !burst_step_n |-> mem_addr[1:0] == 2'($past(addr[1:0]) + 2'h1))
        else $error("linear step wrong");
    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
        sleep_st_r == psabs_pkg::PSABS_AWAKE && sleep_request ##1 sleep_request [*2]
        |=> sleep_st_r == psabs_pkg::PSABS_ASLEEP) else $error("sleep entry not two cycles");
    deselect_a: assert property (@(posedge sys_clk) disable iff (srst)
        deselect |=> !selected_r && !data_io_bus_oe) else $error("deselect ignored");
    step_adv_a: assert property (@(posedge sys_clk) disable iff (srst)
        cont && !burst_step_n |-> mem_addr[BW-1:0] == next_lo ##1 cur_lo == $past(next_lo))
        else $error("burst step did not advance");
    launch_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_c |-> mem_addr == addr ##1 cur_lo == $past(addr[BW-1:0]))
        else $error("controller launch not loaded");
    padsp_first_a: assert property (@(posedge sys_clk) disable iff (srst)
        begin_p |-> mem_addr == addr ##1 cur_lo == $past(addr[BW-1:0]))
        else $error("processor launch not loaded");
    wr_ind_a: assert property (@(posedge sys_clk) disable iff (srst)
        (begin_c || cont) && !byte_write_en_n && byte_lane_write_n != '1 |-> wr_cycle)
        else $error("byte write not detected");
    oe_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(rd_cycle) && selected_r && !output_drive_en_n && !wr_cycle && awake
        |-> data_io_bus_oe) else $error("read data not driven");
    oe_off_a: assert property (@(posedge sys_clk) disable iff (srst)
        output_drive_en_n |-> !data_io_bus_oe) else $error("bus driven with enable high");
    cont_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        cont && chip_sel_1_n && wr_ind |-> lane_we != '0) else $error("continue write lost");
    sleep_leave_a: assert property (@(posedge sys_clk) disable iff (srst)
        sleep_st_r == psabs_pkg::PSABS_ASLEEP && !sleep_request ##1 !sleep_request [*2]
        |=> sleep_st_r == psabs_pkg::PSABS_AWAKE) else $error("sleep exit not two cycles");
    sleep_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
        !awake |-> lane_we == '0 && !rd_cycle) else $error("access taken while asleep");
    deselect_rd_a: assert property (@(posedge sys_clk) disable iff (srst)
        deselect |-> lane_we == '0 && !rd_cycle) else $error("access taken on deselect");

    burst_read_c: cover property (@(posedge sys_clk) disable iff (srst)
        begin_p ##1 (cont && !burst_step_n) [*3]);
    ctrl_write_c: cover property (@(posedge sys_clk) disable iff (srst) begin_c && wr_ind);
    suspend_c: cover property (@(posedge sys_clk) disable iff (srst) cont && burst_step_n);
    byte_write_c: cover property (@(posedge sys_clk) disable iff (srst)
        cont && wr_cycle && global_write_n);
    sleep_c: cover property (@(posedge sys_clk) disable iff (srst)
        sleep_st_r == psabs_pkg::PSABS_ASLEEP ##1 sleep_st_r == psabs_pkg::PSABS_LEAVE);
endmodule

/* include/psabs_pkg.sv */
/*
 Shared constants of the pipelined burst SRAM: array shape, burst
 counter layout and sleep timing. Assumes a single 100 MHz clock.
*/
package psabs_pkg;
    // Array shape: 512K words of four 9-bit lanes
    localparam int ADDR_W   = 19;
    localparam int LANES    = 4;
    localparam int LANE_W   = 9;
    // Burst counter replaces the two low address bits
    localparam int BURST_W  = 2;
    localparam int BURST_LO = 0;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    // Sleep timing, given in clock periods
    localparam int SLEEP_ENTRY_CYC = 2;
    localparam int SLEEP_RECOV_CYC = 2;
    localparam logic [1:0] SLEEP_ENTRY_LOAD = 2'(SLEEP_ENTRY_CYC - 1);
    localparam logic [1:0] SLEEP_RECOV_LOAD = 2'(SLEEP_RECOV_CYC - 1);

    typedef enum logic [1:0] {
        PSABS_AWAKE,
        PSABS_ENTER,
        PSABS_ASLEEP,
        PSABS_LEAVE
    } psabs_sleep_t;
endpackage

/* logic/psabs_mem.sv */
/*
 Storage array with per-lane write enables and a registered read port.
 Assumes the caller never reads and writes in the same cycle.
*/
module psabs_mem #(
    parameter int ADDR_W = psabs_pkg::ADDR_W,
    parameter int LANES  = psabs_pkg::LANES,
    parameter int LANE_W = psabs_pkg::LANE_W
) (
    // Clock
    input  wire logic                      sys_clk,
    // Access
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic [LANES-1:0]          lane_we,
    input  wire logic                      rd_en,
    input  wire logic [LANES*LANE_W-1:0]   wdata,
    // Read data, one cycle after rd_en
    output logic      [LANES*LANE_W-1:0]   rdata
);
    logic [LANES*LANE_W-1:0] mem [2**ADDR_W];
    logic [LANES*LANE_W-1:0] rdata_r;
    logic [LANES*LANE_W-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rd_en ? mem[addr] : rdata_r;
    end

    always_ff @(posedge sys_clk) begin
        rdata_r <= rdata_nxt;
    end

    // Unselected lanes keep their contents
    always_ff @(posedge sys_clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (lane_we[g]) begin
                mem[addr][g*LANE_W +: LANE_W] <= wdata[g*LANE_W +: LANE_W];
            end
        end
    end

    assign rdata = rdata_r;
endmodule

/* logic/psabs_burst.sv */
/*
 Two-bit wraparound burst sequencer in interleaved or linear order.
 Assumes load and step are never both high.
*/
module psabs_burst (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    // Control
    input  wire logic                          load,
    input  wire logic [psabs_pkg::BURST_W-1:0] start_lo,
    input  wire logic                          step,
    input  wire logic                          interleave,
    // Low address now and after one step
    output logic      [psabs_pkg::BURST_W-1:0] cur_lo,
    output logic      [psabs_pkg::BURST_W-1:0] next_lo
);
    logic [psabs_pkg::BURST_W-1:0] start_r;
    logic [psabs_pkg::BURST_W-1:0] start_nxt;
    logic [psabs_pkg::BURST_W-1:0] cnt_r;
    logic [psabs_pkg::BURST_W-1:0] cnt_nxt;
    logic [psabs_pkg::BURST_W-1:0] cnt_inc;

    function automatic logic [psabs_pkg::BURST_W-1:0] seq(
        input logic [psabs_pkg::BURST_W-1:0] s,
        input logic [psabs_pkg::BURST_W-1:0] c,
        input logic                          il
    );
        return il ? (s ^ c) : psabs_pkg::BURST_W'(s + c);
    endfunction

    always_comb begin
        cnt_inc   = psabs_pkg::BURST_W'(cnt_r + 2'h1);
        start_nxt = load ? start_lo : start_r;
        cnt_nxt   = load ? psabs_pkg::BURST_RST : (step ? cnt_inc : cnt_r);
        cur_lo    = seq(start_r, cnt_r, interleave);
        next_lo   = seq(start_r, cnt_inc, interleave);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_r <= psabs_pkg::BURST_RST;
            cnt_r   <= psabs_pkg::BURST_RST;
        end else begin
            start_r <= start_nxt;
            cnt_r   <= cnt_nxt;
        end
    end
endmodule

/* sim/psabs_host_model.sv */
/*
 Far-side model of the shared data wire: resolves device and host drive.
 Assumes the bench raises host_en only while the host owns the wire.
*/
module psabs_host_model #(
    parameter int W = 36
) (
    // Clock
    input  wire logic         sys_clk,
    // Device side
    input  wire logic [W-1:0] dev_data,
    input  wire logic         dev_oe,
    // Host side
    input  wire logic [W-1:0] host_data,
    input  wire logic         host_en,
    // Resolved wire and clash count
    output logic      [W-1:0] bus,
    output int                clash_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_r = '0;
    // Released wire flips every cycle
    always_comb begin
        if (dev_oe) begin
            bus = dev_data;
        end else if (host_en) begin
            bus = host_data;
        end else begin
            bus = ~last_r;
        end
    end
    initial clash_count = 0;
    always @(posedge sys_clk) begin
        last_r <= bus;
        if (dev_oe && host_en) begin
            clash_count <= clash_count + 1;
        end
    end
endmodule

/* sim/test_psabs_top.sv */
/*
 Self-checking bench of the burst SRAM core: writes, byte lanes, bursts
 in both orders, deselects and sleep. Assumes the host model resolves
 the data wire.
*/
module test_psabs_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 6;
    logic          sys_clk, srst, c_n, p_n, s_n, cs1_n, cs2, g_n, b_n, strap, oe_n, zz;
    logic [3:0]    l_n;
    logic [AW-1:0] a_r, base;
    logic [35:0]   bus_i, bus_o, h_d, pend_d;
    logic          bus_oe, h_en, il, live, asleep, pend;
    logic [1:0]    n;
    int            clash, n_errors, check_count;
    logic [31:0]   seed = 32'h40;
    logic [35:0]   shadow [logic [AW-1:0]];

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    psabs_top #(.ADDR_W(AW)) i_psabs_top (
        .sys_clk(sys_clk), .srst(srst), .controller_addr_strobe_n(c_n),
        .processor_addr_strobe_n(p_n), .burst_step_n(s_n), .chip_sel_1_n(cs1_n),
        .chip_sel_2(cs2), .chip_sel_3_n(1'b0), .global_write_n(g_n),
        .byte_write_en_n(b_n), .byte_lane_write_n(l_n), .addr(a_r),
        .burst_order_strap(strap), .output_drive_en_n(oe_n), .sleep_request(zz),
        .data_io_bus_i(bus_i), .data_io_bus_o(bus_o), .data_io_bus_oe(bus_oe)
    );
    psabs_host_model i_psabs_host_model (
        .sys_clk(sys_clk), .dev_data(bus_o), .dev_oe(bus_oe), .host_data(h_d),
        .host_en(h_en), .bus(bus_i), .clash_count(clash)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk_d(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One bus cycle; checks the result of the previous one
    task automatic cyc(input logic c, p, s, input logic [1:0] sel, input logic g, b,
                       input logic [3:0] l, input logic [AW-1:0] a, input logic o);
        logic          ldp, ldc, cnt, wi, wr, rd;
        logic [AW-1:0] ad;
        logic [35:0]   d;
        logic [3:0]    m;
        @(posedge sys_clk);
        d = {rnd(), 4'h0} ^ {4'h0, rnd()};
        ldp = sel == 2'h0 && !p && !asleep;
        ldc = sel == 2'h0 && p && !c && !asleep;
        cnt = c && (p || sel == 2'h2) && live && !asleep;
        wi = !g || (!b && l != 4'hF);
        if (ldp || ldc) begin
            base = a;
            n = 2'h0;
            live = 1'b1;
        end else if (cnt && !s) begin
            n = n + 2'h1;
        end else if (!cnt && !asleep && (!c || !p)) begin
            live = 1'b0;
        end
        ad = (ldp || ldc) ? a : {base[AW-1:2], il ? base[1:0] ^ n : base[1:0] + n};
        wr = (ldc || cnt) && wi;
        rd = ldp || ((ldc || cnt) && !wi);
        m = !g ? 4'hF : ~l;
        c_n <= c;
        p_n <= p;
        s_n <= s;
        cs1_n <= sel == 2'h2;
        cs2 <= sel != 2'h1;
        g_n <= g;
        b_n <= b;
        l_n <= l;
        a_r <= a;
        oe_n <= o;
        h_en <= wr;
        h_d <= d;
        #1;
        chk_b(bus_oe, pend && !o && !wr && !zz);
        if (pend) chk_d(bus_o, pend_d);
        pend = rd;
        pend_d = shadow.exists(ad) ? shadow[ad] : 'x;
        if (wr && !shadow.exists(ad)) shadow[ad] = 'x;
        for (int k = 0; k < 4; k++) if (wr && m[k]) shadow[ad][k*9+:9] = d[k*9+:9];
    endtask
    task automatic idle();
        cyc(1'b0, 1'b1, 1'b1, 2'h2, 1'b1, 1'b1, 4'hF, '0, 1'b0);
    endtask
    task automatic rd_at(input logic [AW-1:0] a, input logic o);
        cyc(1'b1, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 4'hF, a, o);
    endtask
    task automatic step(input logic s, input logic o);
        cyc(1'b1, 1'b1, s, 2'h0, 1'b1, 1'b1, 4'hF, '0, o);
    endtask
    task automatic do_reset(input logic mode);
        @(posedge sys_clk);
        srst <= 1'b1;
        strap <= mode;
        il = mode;
        live = 1'b0;
        pend = 1'b0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        strap <= ~mode;
    endtask
    task automatic bursts();
        logic [AW-1:0] a;
        logic [31:0]   r;
        for (int s = 0; s < 4; s++) begin
            r = rnd();
            a = {r[AW-1:2], 2'(s)};
            rd_at(a, r[8]);
            repeat (4) step(1'b0, r[9]);
            step(1'b1, 1'b0);
            cyc(1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b1, 4'hF, a, 1'b1);
            cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 4'hF, '0, 1'b1);
            cyc(1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 4'h5, '0, 1'b1);
            rd_at(a, 1'b0);
            repeat (3) step(1'b0, 1'b0);
            idle();
        end
        $display("test bursts mode %0d done", il);
    endtask

    initial begin
        {srst, c_n, p_n, s_n, cs1_n, cs2, g_n, b_n, strap, oe_n} = 10'h3FF;
        {zz, h_en, asleep, pend, live} = 5'h0;
        {l_n, a_r, h_d} = '1;
        n_errors = 0;
        check_count = 0;
        do_reset(1'b1);
        for (int k = 0; k < 64; k++) begin
            cyc(1'b0, 1'b1, rnd() > 32'h7FFFFFFF, 2'h0, 1'b0, 1'b1, 4'hF, AW'(k), 1'b1);
        end
        rd_at(6'h3, 1'b0);
        cyc(1'b0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1, 4'hF, 6'h3, 1'b0);
        idle();
        rd_at(6'h3, 1'b0);
        idle();
        $display("test fill done");
        for (int k = 0; k < 16; k++) begin
            cyc(1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0, 4'(~k), AW'(32 + k), 1'b1);
            rd_at(AW'(32 + k), 1'b0);
        end
        cyc(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 4'h0, 6'h8, 1'b0);
        cyc(1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1, 4'hF, '0, 1'b1);
        rd_at(6'h8, 1'b0);
        cyc(1'b1, 1'b0, 1'b1, 2'h1, 1'b1, 1'b1, 4'hF, 6'h5, 1'b0);
        step(1'b0, 1'b0);
        idle();
        $display("test lanes done");
        bursts();
        do_reset(1'b0);
        bursts();
        zz = 1'b1;
        asleep = 1'b1;
        repeat (3) idle();
        cyc(1'b0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1, 4'hF, 6'h3, 1'b0);
        zz = 1'b0;
        repeat (2) idle();
        asleep = 1'b0;
        rd_at(6'h3, 1'b0);
        idle();
        chk_b(clash == 0, 1'b1);
        $display("test sleep done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end
endmodule
